// *** adc_seq_pkg.sv ***
// shared constants and types of the dual-channel conversion sequencer
// assumes one 25 MHz system clock and word-aligned APB register access
package adc_seq_pkg;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX   = 8'h56;
  localparam logic [7:0] STATUS_IDX = 8'h60;
  localparam logic [7:0] IRQ_IDX    = 8'h61;
  localparam logic [7:0] SEQ_IDX    = 8'h62;
  localparam logic [7:0] POWER_IDX  = 8'h63;
  // control register fields
  localparam int CTRL_START_LSB = 0;
  localparam int CTRL_ABORT     = 2;
  localparam int CTRL_MODE_LSB  = 3;
  localparam int CTRL_CHOP      = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // status, irq, sequence config and power fields
  localparam int STATUS_FP         = 0;
  localparam int STATUS_ACTIVE_LSB = 4;
  localparam int IRQ_READY_LSB     = 5;
  localparam int SEQ_SETTLE_LSB    = 0;
  localparam int SEQ_CUR_CNT_LSB   = 4;
  localparam int SEQ_VT_CNT_LSB    = 8;
  localparam logic [10:0] SEQ_RESET = 11'h001;
  localparam int POWER_FP          = 0;
  // timing: modulator period 250 ns, ticked every 6 system cycles (240 ns, about 4.17 MHz)
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int MOD_CLK_PERIOD_NS = 250;
  localparam int MOD_TICK_CYCLES   = MOD_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [15:0] RESULT_MOD_TICKS = 16'h0040;
  typedef enum logic [1:0]
  {
    CH_IDLE   = 2'b00,
    CH_SETTLE = 2'b01,
    CH_ALIGN  = 2'b10,
    CH_RUN    = 2'b11
  } ch_state_t;
endpackage

// *** dual_adc_conversion_sequencer.sv ***
// conversion sequencer for the current and the voltage/temperature channel
// assumes an APB master on SYS_CLK and a filter that consumes FEED levels
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
module dual_adc_conversion_sequencer
(
  input  wire logic                          SYS_CLK,
  input  wire logic                          RESET,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  output logic      [2:0]                    CUR_MUX_MODE,
  output logic      [2:0]                    VT_MUX_MODE,
  output logic      [1:0]                    FILTER_FEED,
  output logic      [1:0]                    RESULT_STROBE,
  output logic      [1:0]                    READY_STROBE,
  output logic      [1:0]                    CONV_ACTIVE
);

  // software visible state
  logic [7:0]  conversion_control_reg;
  logic [10:0] seq_config;
  logic [2:0]  irq_status_reg;
  logic        full_power_state;
  logic        full_power_prev;
  // per channel sequencing
  adc_seq_pkg::ch_state_t ch_state [2];
  logic [1:0]  start_prev;
  logic [1:0]  conv_active_flag;
  logic [3:0]  settle_left [2];
  logic [2:0]  results_left [2];
  logic [2:0]  mode_latched [2];
  // shared timebase
  logic [7:0]  mod_div;
  logic        mod_tick;
  logic [15:0] sample_cnt;
  logic        result_tick;
  logic        run_any;
  // decoded strobes
  logic [1:0]  conv_start_bit;
  logic [1:0]  start_edge;
  logic [1:0]  abort_now;
  logic        power_change;
  logic        wr_access;
  logic        rd_setup;
  logic [7:0]  reg_idx;
  logic        addr_ok;
  logic [2:0]  next_irq;

  // results per sequence: field value n gives n+1 results
  function automatic logic [2:0] seq_len_field(input logic [10:0] cfg, input int ch);
    seq_len_field = (ch == 0) ? cfg[adc_seq_pkg::SEQ_CUR_CNT_LSB +: 3]
                              : cfg[adc_seq_pkg::SEQ_VT_CNT_LSB +: 3];
  endfunction

  // index decode, shared by read and write paths
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == adc_seq_pkg::CTRL_IDX) || (idx == adc_seq_pkg::STATUS_IDX)
              || (idx == adc_seq_pkg::IRQ_IDX) || (idx == adc_seq_pkg::SEQ_IDX)
              || (idx == adc_seq_pkg::POWER_IDX);
  endfunction

  // apb decode; one wait-free access phase, read data latched in setup
  assign reg_idx   = PADDR[9:2];
  assign addr_ok   = idx_mapped(reg_idx) && (PADDR[1:0] == 2'b00)
                  && (PADDR[adc_seq_pkg::ADDR_W-1:10] == 2'b00);
  assign wr_access = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_setup  = PSEL && !PENABLE && !PWRITE;
  assign PREADY    = PSEL && PENABLE;
  assign PSLVERR   = PSEL && PENABLE && !addr_ok;

  // start bits only honoured in full power; power loss looks like a clear
  assign conv_start_bit = conversion_control_reg[adc_seq_pkg::CTRL_START_LSB +: 2]
                        & {2{full_power_state}};
  assign start_edge   = conv_start_bit & ~start_prev;
  assign power_change = full_power_state != full_power_prev;
  assign run_any      = (ch_state[0] == adc_seq_pkg::CH_RUN)
                     || (ch_state[1] == adc_seq_pkg::CH_RUN);

  // abort eligibility per channel; the other channel is untouched
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      abort_now[c] = conv_active_flag[c] && !start_edge[c]
                  && ((!conv_start_bit[c] && full_power_state
                       && conversion_control_reg[adc_seq_pkg::CTRL_ABORT])
                      || power_change);
    end
  end

  // control register; shared fields are software's to keep stable
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      conversion_control_reg <= adc_seq_pkg::CTRL_RESET;
    else if (wr_access && reg_idx == adc_seq_pkg::CTRL_IDX)
      conversion_control_reg <= {1'b0, PWDATA[6:0]};
  end

  // sequence config and power request
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      seq_config       <= adc_seq_pkg::SEQ_RESET;
      full_power_state <= 1'b1;
      full_power_prev  <= 1'b1;
    end
    else
    begin
      full_power_prev <= full_power_state;
      if (wr_access && reg_idx == adc_seq_pkg::SEQ_IDX)
        seq_config <= PWDATA[10:0];
      if (wr_access && reg_idx == adc_seq_pkg::POWER_IDX)
        full_power_state <= PWDATA[adc_seq_pkg::POWER_FP];
    end
  end

  // sticky ready bits, write one to clear; a set in the same cycle wins
  always_comb
  begin
    next_irq = irq_status_reg;
    if (wr_access && reg_idx == adc_seq_pkg::IRQ_IDX)
      next_irq = next_irq & ~PWDATA[adc_seq_pkg::IRQ_READY_LSB +: 3];
    next_irq[1:0] = next_irq[1:0] | READY_STROBE;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      irq_status_reg <= 3'h0;
    else
      irq_status_reg <= next_irq;
  end

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      PRDATA <= 32'h0;
    else if (rd_setup)
    begin
      PRDATA <= 32'h0;
      unique case (addr_ok ? reg_idx : 8'h00)
        adc_seq_pkg::CTRL_IDX:   PRDATA[7:0] <= conversion_control_reg;
        adc_seq_pkg::STATUS_IDX:
        begin
          PRDATA[adc_seq_pkg::STATUS_ACTIVE_LSB +: 2] <= conv_active_flag;
          PRDATA[adc_seq_pkg::STATUS_FP]              <= full_power_state;
        end
        adc_seq_pkg::IRQ_IDX:    PRDATA[adc_seq_pkg::IRQ_READY_LSB +: 3] <= irq_status_reg;
        adc_seq_pkg::SEQ_IDX:    PRDATA[10:0] <= seq_config;
        adc_seq_pkg::POWER_IDX:  PRDATA[adc_seq_pkg::POWER_FP] <= full_power_state;
        default:                 PRDATA <= 32'h0;
      endcase
    end
  end

  // modulator clock tick derived from the system clock
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      mod_div  <= 8'h00;
      mod_tick <= 1'b0;
    end
    else if (mod_div == 8'(adc_seq_pkg::MOD_TICK_CYCLES - 1))
    begin
      mod_div  <= 8'h00;
      mod_tick <= 1'b1;
    end
    else
    begin
      mod_div  <= mod_div + 8'h01;
      mod_tick <= 1'b0;
    end
  end

  // shared result timebase; restarts when no channel is running, which lets
  // a late channel lock onto the running one's result instants
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET || !run_any)
    begin
      sample_cnt  <= 16'h0000;
      result_tick <= 1'b0;
    end
    else if (mod_tick && sample_cnt == adc_seq_pkg::RESULT_MOD_TICKS - 16'h0001)
    begin
      sample_cnt  <= 16'h0000;
      result_tick <= 1'b1;
    end
    else
    begin
      if (mod_tick)
        sample_cnt <= sample_cnt + 16'h0001;
      result_tick <= 1'b0;
    end
  end

  // previous start value for edge detection
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      start_prev <= 2'b00;
    else
      start_prev <= conv_start_bit;
  end

  // per channel sequence state machines
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      for (int c = 0; c < 2; c++)
      begin
        ch_state[c]     <= adc_seq_pkg::CH_IDLE;
        settle_left[c]  <= 4'h0;
        results_left[c] <= 3'h0;
        mode_latched[c] <= 3'h0;
      end
      conv_active_flag <= 2'b00;
      RESULT_STROBE    <= 2'b00;
      READY_STROBE     <= 2'b00;
    end
    else
    begin
      RESULT_STROBE <= 2'b00;
      READY_STROBE  <= 2'b00;
      for (int c = 0; c < 2; c++)
      begin
        if (start_edge[c])
        begin
          // start edge: capture mode, go settle
          ch_state[c]         <= adc_seq_pkg::CH_SETTLE;
          conv_active_flag[c] <= 1'b1;
          mode_latched[c]     <= conversion_control_reg[adc_seq_pkg::CTRL_MODE_LSB +: 3];
          settle_left[c]      <= seq_config[adc_seq_pkg::SEQ_SETTLE_LSB +: 4];
          results_left[c]     <= seq_len_field(seq_config, c);
        end
        else if (abort_now[c])
        begin
          // immediate stop, the abandoned sequence reports nothing
          ch_state[c]         <= adc_seq_pkg::CH_IDLE;
          conv_active_flag[c] <= 1'b0;
        end
        else
        begin
          unique case (ch_state[c])
            adc_seq_pkg::CH_IDLE: ;
            adc_seq_pkg::CH_SETTLE:
            begin
              if (settle_left[c] == 4'h0)
                ch_state[c] <= adc_seq_pkg::CH_ALIGN;
              else if (mod_tick)
                settle_left[c] <= settle_left[c] - 4'h1;
            end
            adc_seq_pkg::CH_ALIGN:
            begin
              // join on a result instant of the other channel, if running
              if (!run_any || result_tick)
                ch_state[c] <= adc_seq_pkg::CH_RUN;
            end
            adc_seq_pkg::CH_RUN:
            begin
              if (result_tick)
              begin
                RESULT_STROBE[c] <= 1'b1;
                if (results_left[c] != 3'h0)
                  results_left[c] <= results_left[c] - 3'h1;
                else
                begin
                  READY_STROBE[c] <= 1'b1;
                  if (conv_start_bit[c])
                    results_left[c] <= seq_len_field(seq_config, c);
                  else
                  begin
                    ch_state[c]         <= adc_seq_pkg::CH_IDLE;
                    conv_active_flag[c] <= 1'b0;
                  end
                end
              end
            end
          endcase
        end
      end
    end
  end

  // filter is fed only once settling has passed
  always_comb
  begin
    for (int c = 0; c < 2; c++)
      FILTER_FEED[c] = (ch_state[c] == adc_seq_pkg::CH_RUN)
                    || (ch_state[c] == adc_seq_pkg::CH_ALIGN);
  end

  assign CUR_MUX_MODE = mode_latched[0];
  assign VT_MUX_MODE  = mode_latched[1];
  assign CONV_ACTIVE  = conv_active_flag;

endmodule

// *** seq_asserts.sv ***
// port checker for the dual-channel conversion sequencer
// assumes it is bound onto the design top; one clock domain
`timescale 1ns/1ns
module seq_asserts
(
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  input wire logic [2:0] CUR_MUX_MODE,
  input wire logic [1:0] FILTER_FEED,
  input wire logic [1:0] RESULT_STROBE,
  input wire logic [1:0] READY_STROBE,
  input wire logic [1:0] CONV_ACTIVE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // bus answers and sequence completion
  chk_zero_wait: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access not answered at once");
  chk_ready_last_result: assert property (READY_STROBE[0] |-> RESULT_STROBE[0])
    else $error("ready without final result");
  chk_ready_was_active: assert property (READY_STROBE[1] |-> $past(CONV_ACTIVE[1]))
    else $error("ready from an idle channel");
  chk_ready_one_cycle: assert property (READY_STROBE[0] |=> !READY_STROBE[0])
    else $error("ready strobe too long");
  chk_result_spacing: assert property (RESULT_STROBE[1] |=> !RESULT_STROBE[1] [*8])
    else $error("results too close");
  // feeding only after settling, never while idle
  chk_feed_needs_active: assert property ((FILTER_FEED & ~CONV_ACTIVE) == 2'b00)
    else $error("filter fed by idle channel");
  chk_settle_first: assert property ($rose(CONV_ACTIVE[0]) |-> !FILTER_FEED[0])
    else $error("settling skipped on start");
  chk_restart_no_settle: assert property (READY_STROBE[0] && CONV_ACTIVE[0] |-> FILTER_FEED[0])
    else $error("continuous restart settled again");
  // mode only moves with a start edge
  chk_mode_on_start: assert property ($changed(CUR_MUX_MODE) |-> CONV_ACTIVE[0] && !FILTER_FEED[0])
    else $error("mode changed without start");
  cover property (READY_STROBE[0] && !CONV_ACTIVE[0]);
  cover property (READY_STROBE[0] && CONV_ACTIVE[0]);
  cover property ($fell(CONV_ACTIVE[0]) && !READY_STROBE[0]);
  cover property (RESULT_STROBE == 2'b11);
endmodule

bind dual_adc_conversion_sequencer seq_asserts chk
(.SYS_CLK, .RESET, .PSEL, .PENABLE, .PREADY, .CUR_MUX_MODE, .FILTER_FEED,
 .RESULT_STROBE, .READY_STROBE, .CONV_ACTIVE);

// *** sw_host.sv ***
// apb master standing in for the controller software
// assumes the slave raises pready; a request is held until then
`timescale 1ns/1ns
module sw_host
(
  input  wire logic                          clk,
  input  wire logic                          pready,
  input  wire logic                          pslverr,
  input  wire logic [31:0]                   prdata,
  output logic                               psel = 1'b0,
  output logic                               penable = 1'b0,
  output logic                               pwrite = 1'b0,
  output logic [adc_seq_pkg::ADDR_W-1:0]     paddr = '0,
  output logic [31:0]                        pwdata = '0
);
  logic [31:0] q;
  logic        err;
  // one transfer; no wait-state count assumed, waits for pready
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the dual-channel conversion sequencer
// assumes the host model as bus master and the bound port checker
`timescale 1ns/1ns
module tb_top;
  logic        SYS_CLK = 1'b0;
  logic        RESET = 1'b1;
  wire         PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  wire  [11:0] PADDR;
  wire  [31:0] PWDATA, PRDATA;
  wire  [2:0]  CUR_MUX_MODE, VT_MUX_MODE;
  wire  [1:0]  FILTER_FEED, RESULT_STROBE, READY_STROBE, CONV_ACTIVE;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_rdy = 0;
  int          n;
  logic [31:0] lfsr = 32'h7f7b292f;
  logic [2:0]  mode;

  dual_adc_conversion_sequencer dut
  (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
   .PSLVERR, .CUR_MUX_MODE, .VT_MUX_MODE, .FILTER_FEED, .RESULT_STROBE,
   .READY_STROBE, .CONV_ACTIVE);
  sw_host host
  (.clk(SYS_CLK), .pready(PREADY), .pslverr(PSLVERR), .prdata(PRDATA), .psel(PSEL),
   .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));

  // 25 MHz clock and a tally of ready strobes
  initial forever #20 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) n_rdy <= n_rdy + int'(READY_STROBE[0]) + int'(READY_STROBE[1]);

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected control word: mode field over abort and start bits
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [2:0] low);
    return {26'h0, m, low};
  endfunction

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // sample a little after the edge so registered outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    host.xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    host.xfer(1'b0, i, 32'h0);
    chk(host.q, e);
  endtask
  // bounded wait for a ready strobe, counting results on the way
  task automatic wait_rdy(input int ch);
    n = 0;
    for (int k = 0; k < 3000; k++)
    begin
      cyc(1);
      n = n + int'(RESULT_STROBE[ch]);
      if (READY_STROBE[ch] === 1'b1)
        break;
    end
    chk({31'h0, READY_STROBE[ch]}, 32'h1);
  endtask

  // watchdog well beyond the few thousand cycles the tests take
  initial
  begin
    repeat (40000) @(posedge SYS_CLK);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(posedge SYS_CLK);
    RESET <= 1'b0;
    // reset values and a refused access
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h0);
    chk({31'h0, host.err}, 32'h1);
    rd(adc_seq_pkg::CTRL_IDX, 32'h0);
    rd(adc_seq_pkg::STATUS_IDX, 32'h1);
    rd(adc_seq_pkg::SEQ_IDX, 32'h1);
    wr(adc_seq_pkg::CTRL_IDX, 32'hc0);
    rd(adc_seq_pkg::CTRL_IDX, 32'h40);
    // one-shot sequence of three results with a random mode
    lfsr = nxt(lfsr);
    mode = lfsr[2:0];
    wr(adc_seq_pkg::SEQ_IDX, 32'h21);
    wr(adc_seq_pkg::CTRL_IDX, cw(mode, 3'b001));
    rd(adc_seq_pkg::CTRL_IDX, cw(mode, 3'b001));
    wr(adc_seq_pkg::CTRL_IDX, cw(mode, 3'b000));
    rd(adc_seq_pkg::STATUS_IDX, 32'h11);
    chk(CUR_MUX_MODE, mode);
    wait_rdy(0);
    chk(n, 3);
    chk(CONV_ACTIVE, 2'b00);
    rd(adc_seq_pkg::IRQ_IDX, 32'h20);
    cyc(20);
    rd(adc_seq_pkg::IRQ_IDX, 32'h20);
    wr(adc_seq_pkg::IRQ_IDX, 32'h20);
    rd(adc_seq_pkg::IRQ_IDX, 32'h0);
    wr(adc_seq_pkg::SEQ_IDX, 32'h1);
    // continuous run, abort refused while start is set, then taken
    lfsr = nxt(lfsr);
    mode = lfsr[2:0];
    wr(adc_seq_pkg::CTRL_IDX, cw(mode, 3'b001));
    wait_rdy(0);
    chk(CONV_ACTIVE, 2'b01);
    chk(FILTER_FEED, 2'b01);
    wr(adc_seq_pkg::CTRL_IDX, cw(mode, 3'b101));
    cyc(3);
    chk(CONV_ACTIVE, 2'b01);
    n = n_rdy;
    wr(adc_seq_pkg::CTRL_IDX, cw(mode, 3'b100));
    cyc(2);
    chk(CONV_ACTIVE, 2'b00);
    cyc(400);
    chk(n_rdy, n);
    // second channel aligns to the running one; shared abort hits one
    wr(adc_seq_pkg::CTRL_IDX, 32'h1);
    wait_rdy(0);
    lfsr = nxt(lfsr);
    mode = lfsr[2:0];
    wr(adc_seq_pkg::CTRL_IDX, cw(mode, 3'b011));
    wait_rdy(1);
    chk(RESULT_STROBE, 2'b11);
    chk(VT_MUX_MODE, mode);
    chk(CUR_MUX_MODE, 3'h0);
    rd(adc_seq_pkg::IRQ_IDX, 32'h60);
    wr(adc_seq_pkg::CTRL_IDX, 32'h6);
    cyc(2);
    chk(CONV_ACTIVE, 2'b10);
    wr(adc_seq_pkg::CTRL_IDX, 32'h4);
    cyc(2);
    chk(CONV_ACTIVE, 2'b00);
    // power down aborts, wake-up resumes a still-set start
    wr(adc_seq_pkg::CTRL_IDX, 32'h1);
    cyc(5);
    wr(adc_seq_pkg::POWER_IDX, 32'h0);
    cyc(2);
    chk(CONV_ACTIVE, 2'b00);
    rd(adc_seq_pkg::STATUS_IDX, 32'h0);
    wr(adc_seq_pkg::POWER_IDX, 32'h1);
    cyc(3);
    chk(CONV_ACTIVE, 2'b01);
    wr(adc_seq_pkg::CTRL_IDX, 32'h4);
    cyc(2);
    // continuous run ended by clearing start only, then polled
    wr(adc_seq_pkg::CTRL_IDX, 32'h1);
    wait_rdy(0);
    wr(adc_seq_pkg::CTRL_IDX, 32'h0);
    rd(adc_seq_pkg::STATUS_IDX, 32'h11);
    wait_rdy(0);
    chk(CONV_ACTIVE, 2'b00);
    rd(adc_seq_pkg::STATUS_IDX, 32'h01);
    stop_test();
  end
endmodule
